// File: src/sat_top.sv
`timescale 1ns/100ps
module sat_top
  import sat_pkg::*;
(
  input  wire logic                  clk_sys_in,      // 10 MHz clock
  input  wire logic                  nrst_in,         // sync reset, low
  input  wire logic [LINE_COUNT-1:0] trig_line_in,    // async trig lines
  input  wire logic                  host_trig_in,    // host trigger pulse
  input  wire logic                  cfg_load_in,     // load settings
  input  wire logic [SRC_W-1:0]      trigger_source_select_in, // source
  input  wire logic                  trigger_kind_in, // pulse or level
  input  wire logic                  trigger_active_sense_in, // sense
  input  wire logic [IDX_W-1:0]      list_last_in,    // last entry index
  input  wire logic                  list_wr_in,      // write list entry
  input  wire logic [IDX_W-1:0]      list_addr_in,    // entry address
  input  wire logic [FREQ_W-1:0]     list_data_in,    // entry frequency
  input  wire logic                  scan_start_in,   // start scan pulse
  input  wire logic                  scan_stop_in,    // stop scan pulse
  output logic [FREQ_W-1:0]          freq_word_out,   // tuned frequency
  output logic [IDX_W-1:0]           scan_index_out,  // current entry
  output logic                       tune_start_out,  // retune pulse
  output logic                       ready_out        // settled
);
  sat_line_if line_bus ();

  sat_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .lines_in   (trig_line_in),
    .sync_out   (line_bus)
  );

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  logic [SRC_W-1:0] src_reg;
  logic             kind_reg;
  logic             sense_reg;
  logic [IDX_W-1:0] last_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      src_reg   <= source_from_host_command;
      kind_reg  <= kind_pulse_detect;
      sense_reg <= sense_low_true;
      last_reg  <= LAST_RESET;
    end
    else if (cfg_load_in)
    begin
      src_reg   <= trigger_source_select_in;
      kind_reg  <= trigger_kind_in;
      sense_reg <= trigger_active_sense_in;
      last_reg  <= list_last_in;
    end
  end

  // ----------------------------------------------------------------
  // scan list storage
  // ----------------------------------------------------------------
  logic [FREQ_W-1:0] list_mem [SCAN_DEPTH];

  always_ff @(posedge clk_sys_in)
  begin
    if (list_wr_in)
      list_mem[list_addr_in] <= list_data_in;
  end

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  logic             host_sel;
  logic [IDX_W-1:0] line_idx;
  logic             sel_line;
  logic             sel_active;
  logic             prev_active_reg;
  logic             hw_event;
  logic             adv_req;
  logic             accept;
  sat_state_type    state_reg;

  assign host_sel   = (src_reg == source_from_host_command);
  assign line_idx   = IDX_W'(src_reg - source_line_base);
  // host code maps past the last line; read a quiet zero there
  assign sel_line   = host_sel ? 1'b0 : line_bus.level[line_idx];
  // map the chosen sense onto a true-when-active level
  assign sel_active = (sense_reg == sense_high_true) ? sel_line
                                                     : !sel_line;

  // pulse kind needs a fresh move toward the sense; level kind keeps
  // advancing after each settle while the line stays active
  assign hw_event = (kind_reg == kind_pulse_detect)
                    ? (sel_active && !prev_active_reg)
                    : sel_active;
  assign adv_req  = host_sel ? host_trig_in : hw_event;
  // triggers during settling are dropped, not queued
  assign accept   = adv_req && (state_reg == ST_READY);

  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      prev_active_reg <= 1'b1;
    else if (cfg_load_in)
      // re-arm only after the new line is seen inactive
      prev_active_reg <= 1'b1;
    else
      prev_active_reg <= sel_active;
  end

  // ----------------------------------------------------------------
  // scan stepping and settling
  // ----------------------------------------------------------------
  logic [IDX_W-1:0]  idx_reg;
  logic [IDX_W-1:0]  idx_next;
  logic [FREQ_W-1:0] freq_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              tune_reg;

  assign idx_next = (idx_reg == last_reg) ? IDX_FIRST
                                          : idx_reg + IDX_STEP;

  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= ST_IDLE;
      idx_reg   <= IDX_FIRST;
      freq_reg  <= FREQ_RESET;
      cnt_reg   <= CNT_ZERO;
      tune_reg  <= 1'b0;
    end
    else
    begin
      tune_reg <= 1'b0;
      if (scan_stop_in)
        state_reg <= ST_IDLE;
      else if (scan_start_in)
      begin
        idx_reg   <= IDX_FIRST;
        freq_reg  <= list_mem[IDX_FIRST];
        cnt_reg   <= CNT_ZERO;
        tune_reg  <= 1'b1;
        state_reg <= ST_SETTLE;
      end
      else
      begin
        unique case (state_reg)
          ST_IDLE:
            cnt_reg <= CNT_ZERO;
          ST_SETTLE:
            if (cnt_reg == SETTLE_COUNT - CNT_STEP)
              state_reg <= ST_READY;
            else
              cnt_reg <= cnt_reg + CNT_STEP;
          ST_READY:
            if (accept)
            begin
              idx_reg   <= idx_next;
              freq_reg  <= list_mem[idx_next];
              cnt_reg   <= CNT_ZERO;
              tune_reg  <= 1'b1;
              state_reg <= ST_SETTLE;
            end
        endcase
      end
    end
  end

  assign freq_word_out  = freq_reg;
  assign scan_index_out = idx_reg;
  assign tune_start_out = tune_reg;
  assign ready_out      = (state_reg == ST_READY);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  logic [CNT_W-1:0] since_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      since_reg <= CNT_ZERO;
    else if (tune_reg)
      since_reg <= CNT_STEP;
    else if (since_reg != {CNT_W{1'b1}})
      since_reg <= since_reg + CNT_STEP;
  end

  sequence s_retune;
    accept ##1 (tune_start_out && !ready_out);
  endsequence

  sequence s_settling;
    !ready_out [*8];
  endsequence

  chk_step_next: assert property (
    accept && !scan_start_in && !scan_stop_in
    |=> scan_index_out == $past(idx_next) &&
        freq_word_out == list_mem[scan_index_out])
    else $error("accepted trigger did not step to next entry");

  chk_host_only: assert property (
    host_sel && !host_trig_in && !scan_start_in |=> !tune_start_out)
    else $error("advance without host command under host source");

  chk_lines_ignored: assert property (
    host_sel && $changed(line_bus.level) && !host_trig_in &&
    !scan_start_in |=> !tune_start_out)
    else $error("trigger line acted while host source chosen");

  chk_pulse_edge: assert property (
    !host_sel && kind_reg == kind_pulse_detect && accept
    |-> sel_active && !$past(sel_active))
    else $error("pulse kind advanced without a fresh edge");

  chk_level_hold: assert property (
    !host_sel && kind_reg == kind_level_detect && ready_out &&
    sel_active && !scan_start_in && !scan_stop_in |=> tune_start_out)
    else $error("level kind did not advance on active level");

  chk_sense_map: assert property (
    !host_sel && accept |-> sel_line == sense_reg)
    else $error("line advanced while not at the chosen sense");

  chk_ready_hold: assert property (
    s_retune |-> s_settling)
    else $error("ready raised during settling");

  chk_settle_time: assert property (
    $rose(ready_out) |-> since_reg == SETTLE_COUNT)
    else $error("ready not raised exactly at end of settling");
endmodule

// File: inc/sat_pkg.sv
package sat_pkg;
  localparam int LINE_COUNT = 7;
  localparam int SRC_W      = 3;
  localparam int IDX_W      = 3;
  localparam int SCAN_DEPTH = 8;
  localparam int FREQ_W     = 32;
  localparam int CNT_W      = 16;

  // source codes: host command, then lines 0..6 as codes 1..7
  localparam logic [SRC_W-1:0] source_from_host_command = 3'h0;
  localparam logic [SRC_W-1:0] source_line_base         = 3'h1;
  localparam logic kind_pulse_detect = 1'b0;
  localparam logic kind_level_detect = 1'b1;
  localparam logic sense_low_true    = 1'b0;
  localparam logic sense_high_true   = 1'b1;

  localparam logic [IDX_W-1:0] IDX_FIRST  = 3'h0;
  localparam logic [IDX_W-1:0] IDX_STEP   = 3'h1;
  localparam logic [IDX_W-1:0] LAST_RESET = 3'h7;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0000_0000;

  // settling time of the converter after a retune
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SETTLE_TIME_US  = 100;
  localparam int SETTLE_CYCLES   =
    (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] SETTLE_COUNT = CNT_W'(SETTLE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ZERO     = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_STEP     = 16'h0001;

  typedef enum {ST_IDLE, ST_SETTLE, ST_READY} sat_state_type;
endpackage

// File: inc/sat_line_if.sv
`timescale 1ns/100ps
interface sat_line_if;
  logic [sat_pkg::LINE_COUNT-1:0] level;
  modport drive (output level);
  modport take  (input level);
endinterface

// File: src/sat_sync.sv
`timescale 1ns/100ps
module sat_sync
  import sat_pkg::*;
(
  input  wire logic                  clk_sys_in,   // system clock
  input  wire logic                  nrst_in,      // sync reset, low
  input  wire logic [LINE_COUNT-1:0] lines_in,     // async trigger lines
  sat_line_if.drive                  sync_out      // synchronised lines
);
  logic [LINE_COUNT-1:0] meta_reg;
  logic [LINE_COUNT-1:0] sync_reg;

  // ----------------------------------------------------------------
  // two flop synchroniser per line
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LINE_COUNT; g++)
    begin : gen_line
      always_ff @(posedge clk_sys_in)
      begin
        if (!nrst_in)
        begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= lines_in[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sync_out.level = sync_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_sync_depth: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $past(nrst_in, 2) |-> sync_reg == $past(lines_in, 2))
    else $error("line synchroniser is not two flops deep");
endmodule

// File: tb/sat_trig_src.sv
`timescale 1ns/100ps
module sat_trig_src
  import sat_pkg::*;
(
  input  wire logic                  clk_sys_in, // system clock
  output logic      [LINE_COUNT-1:0] line_out    // trigger lines
);
  initial line_out = 7'h7f;
  // pulse toward the sense, then back to the idle level
  task automatic pulse(input int n, input logic act, input int len);
    @(posedge clk_sys_in);
    line_out[n] <= act;
    repeat (len) @(posedge clk_sys_in);
    line_out[n] <= ~act;
  endtask
  task automatic hold(input int n, input logic lvl);
    @(posedge clk_sys_in);
    line_out[n] <= lvl;
  endtask
endmodule

// File: tb/sat_top_tb_top.sv
`timescale 1ns/100ps
module sat_top_tb_top
  import sat_pkg::*;
;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [6:0]        lines;
  logic              host = 1'b0;
  logic              load = 1'b0;
  logic [2:0]        src = 3'h0;
  logic              kind = 1'b0;
  logic              sense = 1'b0;
  logic [2:0]        last = 3'h7;
  logic              wr = 1'b0;
  logic [2:0]        addr = 3'h0;
  logic [31:0]       data = 32'h0;
  logic              start = 1'b0;
  logic              stop = 1'b0;
  logic [31:0]       freq;
  logic [2:0]        idx;
  logic              tune;
  logic              rdy;
  int                n_errors = 0;
  int                tests_run = 0;

  initial forever #50 clk = ~clk;

  sat_trig_src src_u (.clk_sys_in(clk), .line_out(lines));

  sat_top dut_u (
    .clk_sys_in(clk), .nrst_in(nrst), .trig_line_in(lines),
    .host_trig_in(host), .cfg_load_in(load),
    .trigger_source_select_in(src), .trigger_kind_in(kind),
    .trigger_active_sense_in(sense), .list_last_in(last),
    .list_wr_in(wr), .list_addr_in(addr), .list_data_in(data),
    .scan_start_in(start), .scan_stop_in(stop), .freq_word_out(freq),
    .scan_index_out(idx), .tune_start_out(tune), .ready_out(rdy));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] f_of(input logic [2:0] i);
    return {29'h0abc_def0, i};
  endfunction

  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // which: 0 host trigger, 1 scan start, 2 scan stop
  task automatic pulse_in(input int which);
    @(posedge clk);
    host <= (which == 0);
    start <= (which == 1);
    stop <= (which == 2);
    @(posedge clk);
    host <= 1'b0;
    start <= 1'b0;
    stop <= 1'b0;
  endtask

  task automatic cfg(input logic [2:0] s, input logic k, input logic p,
                     input logic [2:0] l);
    @(posedge clk);
    src <= s;
    kind <= k;
    sense <= p;
    last <= l;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask

  // a step is seen, then settling takes the fixed count
  task automatic wait_step(input logic [2:0] i);
    int n;
    n = 0;
    // callers return on or before the launching edge; look once it has settled
    #1;
    while (tune !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(n < 60, "no step");
    if (n == 60) end_sim();
    check(idx === i && freq === f_of(i), "wrong entry");
    check(rdy === 1'b0, "ready too early");
    n = 0;
    while (rdy !== 1'b1 && n < 1100)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(n == SETTLE_CYCLES, "settle count");
    if (n == 1100) end_sim();
  endtask

  task automatic no_step();
    bit seen;
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge clk);
      #1 if (tune !== 1'b0) seen = 1'b1;
    end
    check(!seen, "unexpected step");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_host();
    src_u.pulse(0, 1'b0, 3);
    no_step();
    pulse_in(0);
    wait_step(3'h1);
  endtask

  task automatic t_line_pulse();
    src_u.hold(3, 1'b0);
    cfg(3'h4, kind_pulse_detect, sense_high_true, 3'h7);
    pulse_in(0);
    no_step();
    src_u.pulse(2, 1'b0, 3);
    no_step();
    src_u.pulse(3, 1'b1, 3);
    wait_step(3'h2);
    no_step();
  endtask

  // held level repeats; list wraps after the last entry
  task automatic t_level();
    cfg(3'h7, kind_level_detect, sense_low_true, 3'h2);
    src_u.hold(6, 1'b0);
    wait_step(3'h0);
    wait_step(3'h1);
    // release lands on the ready edge, so one more step is taken
    src_u.hold(6, 1'b1);
    wait_step(3'h2);
    no_step();
  endtask

  // stop drops triggers until a new start
  task automatic t_stop();
    pulse_in(2);
    #1 check(rdy === 1'b0, "ready after stop");
    src_u.hold(6, 1'b0);
    no_step();
    src_u.hold(6, 1'b1);
    pulse_in(1);
    wait_step(3'h0);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1 check(rdy === 1'b0 && tune === 1'b0 && idx === 3'h0 &&
             freq === 32'h0, "reset");
    for (int i = 0; i < SCAN_DEPTH; i++)
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= i[2:0];
      data <= f_of(i[2:0]);
    end
    @(posedge clk);
    wr <= 1'b0;
    pulse_in(1);
    wait_step(3'h0);
    t_host();
    t_line_pulse();
    t_level();
    t_stop();
    end_sim();
  end
endmodule
